/* File: logic/wdog_pkg.sv */
// constants, register map and types of the windowed watchdog
package wdog_pkg;
  localparam int CNT_W = 24;
  localparam int WARN_W = 10;
  localparam int ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_FEED = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_CLKSEL = 8'h10;
  localparam logic [7:0] ADDR_WARN = 8'h14;
  localparam logic [7:0] ADDR_WINDOW = 8'h18;
  // mode register fields
  localparam int MODE_EN = 0;
  localparam int MODE_RSTEN = 1;
  localparam int MODE_TOF = 2;
  localparam int MODE_WARNF = 3;
  localparam int MODE_RSTF = 4;
  // feed values and reset values
  localparam logic [7:0] FEED_FIRST = 8'haa;
  localparam logic [7:0] FEED_SECOND = 8'h55;
  localparam logic [CNT_W-1:0] TIMEOUT_MIN = 24'h0000ff;
  localparam logic [CNT_W-1:0] TIMEOUT_RST = 24'h0000ff;
  localparam logic [CNT_W-1:0] WINDOW_RST = 24'hffffff;
  localparam logic [WARN_W-1:0] WARN_RST = 10'h000;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  // watchdog count clock sources
  localparam logic [1:0] CLK_RCOSC = 2'h0;
  localparam logic [1:0] CLK_WDOSC = 2'h1;
  localparam logic [1:0] CLK_MAIN = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FS_IDLE = 2'h1,
    FS_ARMED = 2'h2
  } feed_state_t;
endpackage

/* File: logic/windowed_watchdog.sv */
// windowed watchdog timer with an axi4-lite register slave
//
// Overview of operation
// - When enabled and not fed before the counter runs out, the block resets the chip.
// - The 24-bit counter steps once every four ticks of the watchdog count clock.
// - The timeout is 256 to 2**24 steps of four count-clock periods.
// - Software can set the enable but not clear it; only reset or a watchdog event does.
// - A wrong or broken feed sequence is a fault that resets or interrupts when enabled.
// - A flag records that the chip reset was caused by the watchdog.
// - The count clock is the rc oscillator, watchdog oscillator or main clock.
// - A feed while the count is above the window value is a fault.
// - A warning interrupt fires on the step taken while the count equals the programmed warning value.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module windowed_watchdog
  import wdog_pkg::*;
#(
  parameter bit WINDOWED = 1'b1
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic porRst_n,
  // count clock ticks, one cycle per source period
  input wire logic rcOscTick,
  input wire logic wdOscTick,
  input wire logic mainTick,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // chip reset request and interrupt
  output logic chipReset,
  output logic wdIrq
);

  typedef struct packed {
    logic enable, resetEn, toFlag, warnFlag;
    logic [1:0] clkSel;
    logic [CNT_W-1:0] timeout, window;
    logic [WARN_W-1:0] warn;
    logic [CNT_W-1:0] count;
    logic [1:0] pre;
    feed_state_t feed;
    logic awFull, wFull;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awRdy, wRdy;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic chipRst, irq;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic rstFlag_reg;
  logic selTick, step, expire, feedOk, feedBad, windowBad, evt;
  logic rstFlagSet, rstFlagClr, doWrite, doRead;

  function automatic logic regHit(input logic [ADDR_W-1:0] a);
    regHit = (a == ADDR_MODE) || (a == ADDR_TIMEOUT) || (a == ADDR_FEED) ||
      (a == ADDR_COUNT) || (a == ADDR_CLKSEL) || (a == ADDR_WARN) || (a == ADDR_WINDOW);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  always_comb begin
    logic [31:0] wv;
    wv = 32'h0;
    state_next = state_reg;
    state_next.chipRst = 1'b0;
    feedOk = 1'b0;
    feedBad = 1'b0;
    rstFlagClr = 1'b0;
    rstFlagSet = 1'b0;
    expire = 1'b0;
    doWrite = state_reg.awFull && state_reg.wFull;
    doRead = arvalid && state_reg.arRdy;
    case (state_reg.clkSel)
      CLK_WDOSC: selTick = wdOscTick;
      CLK_MAIN: selTick = mainTick;
      default: selTick = rcOscTick;
    endcase
    step = state_reg.enable && selTick && (state_reg.pre == PRESCALE_LAST);
    // bus channels
    if (awvalid && state_reg.awRdy) begin
      state_next.awFull = 1'b1;
      state_next.awAddr = awaddr;
    end
    if (wvalid && state_reg.wRdy) begin
      state_next.wFull = 1'b1;
      state_next.wData = wdata;
      state_next.wStrb = wstrb;
    end
    if (bready && state_reg.bValid) state_next.bValid = 1'b0;
    if (rready && state_reg.rValid) state_next.rValid = 1'b0;
    // count clock prescaler and down-counter
    if (state_reg.enable && selTick) state_next.pre = state_reg.pre + 2'h1;
    if (step) begin
      if (state_reg.count == '0) expire = 1'b1;
      else state_next.count = state_reg.count - 24'h000001;
    end
    // any access between the two feed writes breaks the sequence
    if (doRead) begin
      state_next.rValid = 1'b1;
      state_next.rResp = regHit(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        ADDR_MODE: state_next.rData = {27'h0, rstFlag_reg, state_reg.warnFlag,
                                       state_reg.toFlag, state_reg.resetEn, state_reg.enable};
        ADDR_TIMEOUT: state_next.rData = {8'h0, state_reg.timeout};
        ADDR_COUNT: state_next.rData = {8'h0, state_reg.count};
        ADDR_CLKSEL: state_next.rData = {30'h0, state_reg.clkSel};
        ADDR_WARN: state_next.rData = {22'h0, state_reg.warn};
        ADDR_WINDOW: state_next.rData = {8'h0, state_reg.window};
        default: state_next.rData = 32'h0;
      endcase
      if (state_reg.feed == FS_ARMED) begin
        feedBad = 1'b1;
        state_next.feed = FS_IDLE;
      end
    end
    if (doWrite) begin
      state_next.awFull = 1'b0;
      state_next.wFull = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp = regHit(state_reg.awAddr) ? RESP_OKAY : RESP_SLVERR;
      case (state_reg.awAddr)
        ADDR_MODE: wv = merge({27'h0, rstFlag_reg, state_reg.warnFlag, state_reg.toFlag,
                               state_reg.resetEn, state_reg.enable}, state_reg.wData,
                              state_reg.wStrb);
        ADDR_TIMEOUT: wv = merge({8'h0, state_reg.timeout}, state_reg.wData, state_reg.wStrb);
        ADDR_CLKSEL: wv = merge({30'h0, state_reg.clkSel}, state_reg.wData, state_reg.wStrb);
        ADDR_WARN: wv = merge({22'h0, state_reg.warn}, state_reg.wData, state_reg.wStrb);
        ADDR_WINDOW: wv = merge({8'h0, state_reg.window}, state_reg.wData, state_reg.wStrb);
        default: wv = merge(32'h0, state_reg.wData, state_reg.wStrb);
      endcase
      if (state_reg.awAddr == ADDR_FEED) begin
        if (state_reg.feed == FS_ARMED) begin
          state_next.feed = FS_IDLE;
          if (wv[7:0] == FEED_SECOND) feedOk = 1'b1;
          else feedBad = 1'b1;
        end else if (wv[7:0] == FEED_FIRST) begin
          state_next.feed = FS_ARMED;
        end
      end else begin
        if (state_reg.feed == FS_ARMED) begin
          feedBad = 1'b1;
          state_next.feed = FS_IDLE;
        end
        case (state_reg.awAddr)
          ADDR_MODE: begin
            // enable is write-once; writing zero has no effect
            if (wv[MODE_EN] && !state_reg.enable) begin
              state_next.enable = 1'b1;
              state_next.count = state_reg.timeout;
              state_next.pre = 2'h0;
            end
            state_next.resetEn = wv[MODE_RSTEN];
            if (wv[MODE_TOF]) state_next.toFlag = 1'b0;
            if (wv[MODE_WARNF]) state_next.warnFlag = 1'b0;
            rstFlagClr = wv[MODE_RSTF];
          end
          ADDR_TIMEOUT: state_next.timeout = (wv[CNT_W-1:0] < TIMEOUT_MIN) ?
                                             TIMEOUT_MIN : wv[CNT_W-1:0];
          ADDR_CLKSEL: begin
            // main clock is not offered on the windowed variant
            if (!(WINDOWED && wv[1:0] == CLK_MAIN) && wv[1:0] <= CLK_MAIN) begin
              state_next.clkSel = wv[1:0];
            end
          end
          ADDR_WARN: state_next.warn = wv[WARN_W-1:0];
          ADDR_WINDOW: state_next.window = wv[CNT_W-1:0];
          default: ;
        endcase
      end
    end
    windowBad = feedOk && (state_reg.count > state_reg.window);
    if (feedOk && !windowBad) begin
      state_next.count = state_reg.timeout;
      state_next.pre = 2'h0;
    end
    evt = expire || (state_reg.enable && (feedBad || windowBad));
    // sets come after clears so an event is never lost
    if (step && state_reg.count == {{(CNT_W-WARN_W){1'b0}}, state_reg.warn}) begin
      state_next.warnFlag = 1'b1;
    end
    if (evt) begin
      state_next.enable = 1'b0;
      if (state_reg.resetEn) begin
        state_next.chipRst = 1'b1;
        rstFlagSet = 1'b1;
      end else begin
        state_next.toFlag = 1'b1;
      end
    end
    state_next.irq = state_next.toFlag || state_next.warnFlag;
    state_next.awRdy = !state_next.awFull && !state_next.bValid;
    state_next.wRdy = !state_next.wFull && !state_next.bValid;
    state_next.arRdy = !state_next.rValid;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{enable: 1'b0, resetEn: 1'b0, toFlag: 1'b0, warnFlag: 1'b0,
                     clkSel: CLK_RCOSC, timeout: TIMEOUT_RST, window: WINDOW_RST,
                     warn: WARN_RST, count: TIMEOUT_RST, pre: 2'h0, feed: FS_IDLE,
                     awFull: 1'b0, wFull: 1'b0, awAddr: 8'h00, wData: 32'h0,
                     wStrb: 4'h0, awRdy: 1'b0, wRdy: 1'b0, bValid: 1'b0,
                     bResp: RESP_OKAY, arRdy: 1'b0, rValid: 1'b0, rData: 32'h0,
                     rResp: RESP_OKAY, chipRst: 1'b0, irq: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // held only by power-on reset so it outlives the chip reset it reports
  always_ff @(posedge clk_sys or negedge porRst_n) begin
    if (!porRst_n) begin
      rstFlag_reg <= 1'b0;
    end else if (rstFlagSet) begin
      rstFlag_reg <= 1'b1;
    end else if (rstFlagClr) begin
      rstFlag_reg <= 1'b0;
    end
  end

  assign awready = state_reg.awRdy;
  assign wready = state_reg.wRdy;
  assign bvalid = state_reg.bValid;
  assign bresp = state_reg.bResp;
  assign arready = state_reg.arRdy;
  assign rvalid = state_reg.rValid;
  assign rdata = state_reg.rData;
  assign rresp = state_reg.rResp;
  assign chipReset = state_reg.chipRst;
  assign wdIrq = state_reg.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_expire_reset: assert property (step && state_reg.count == '0
    && state_reg.resetEn |=> chipReset) else $error("expiry without chip reset");
  chk_step_four: assert property (state_reg.enable && !step && !doWrite
    |=> $stable(state_reg.count)) else $error("count moved between prescaler steps");
  chk_timeout_min: assert property (state_reg.timeout >= TIMEOUT_MIN)
    else $error("timeout below minimum");
  chk_enable_sticky: assert property (state_reg.enable && !evt |=> state_reg.enable)
    else $error("enable dropped without event");
  chk_bad_feed: assert property (state_reg.enable && feedBad && state_reg.resetEn
    |=> chipReset ##1 !chipReset) else $error("bad feed not punished");
  chk_reset_flag: assert property (chipReset |-> rstFlag_reg [*2])
    else $error("watchdog reset flag not set");
  chk_clk_select: assert property (WINDOWED |-> state_reg.clkSel != CLK_MAIN)
    else $error("main clock selected on windowed variant");
  chk_window_fault: assert property (state_reg.enable && windowBad
    && !state_reg.resetEn |=> wdIrq && !state_reg.enable) else $error("early feed not flagged");
  chk_warn_flag: assert property (step && state_reg.count == {14'h0, state_reg.warn}
    |=> state_reg.warnFlag && wdIrq) else $error("warning not raised");
  chk_feed_reload: assert property (feedOk && !windowBad
    |=> state_reg.count == $past(state_reg.timeout)) else $error("feed did not reload");

  cov_timeout: cover property (state_reg.enable ##1 expire);
  cov_good_feed: cover property (feedOk && !windowBad);
  cov_warn: cover property ($rose(state_reg.warnFlag));

endmodule // windowed_watchdog

/* File: sim/windowed_watchdog_timer_tb_top.sv */
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module windowed_watchdog_timer_tb_top;
  import wdog_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic porRst_n = 1'b0;
  logic rcOscTick = 1'b0;
  logic wdOscTick = 1'b0;
  logic mainTick = 1'b0;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0, chipReset, wdIrq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, lastResp;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int resetPulses = 0;

  always #12.5 clk_sys = ~clk_sys;

  windowed_watchdog u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .porRst_n(porRst_n),
    .rcOscTick(rcOscTick), .wdOscTick(wdOscTick), .mainTick(mainTick),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .chipReset(chipReset), .wdIrq(wdIrq));

  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // run is about 1300 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (chipReset === 1'b1) resetPulses++;
    if (cycles >= 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // handshakes judged on the settled values before each rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awHs, wHs, bHs;
    int n;
    n = 0;
    bHs = 1'b0;
    // fresh edge so the last task's releases never meet new requests
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bHs && n < 50) begin
      @(negedge clk_sys);
      awHs = awvalid && awready;
      wHs = wvalid && wready;
      bHs = bvalid && bready;
      lastResp = bresp;
      @(posedge clk_sys);
      if (awHs) awvalid <= 1'b0;
      if (wHs) wvalid <= 1'b0;
      if (bHs) bready <= 1'b0;
      n++;
    end
    if (!bHs) check(32'h1, 32'h0, "write hang");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic arHs, rHs;
    int n;
    n = 0;
    rHs = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rHs && n < 50) begin
      @(negedge clk_sys);
      arHs = arvalid && arready;
      rHs = rvalid && rready;
      d = rdata;
      lastResp = rresp;
      @(posedge clk_sys);
      if (arHs) arvalid <= 1'b0;
      if (rHs) rready <= 1'b0;
      n++;
    end
    if (!rHs) check(32'h1, 32'h0, "read hang");
  endtask

  task automatic rdExp(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp, "register");
  endtask

  task automatic feed();
    wr(ADDR_FEED, {24'h0, FEED_FIRST});
    wr(ADDR_FEED, {24'h0, FEED_SECOND});
  endtask

  // n count-clock ticks on one source; idle edge first so back-to-back calls never collide
  task automatic ticks(input int n, input logic [1:0] src);
    @(posedge clk_sys);
    if (src == CLK_WDOSC) wdOscTick <= 1'b1;
    else if (src == CLK_MAIN) mainTick <= 1'b1;
    else rcOscTick <= 1'b1;
    repeat (n) @(posedge clk_sys);
    rcOscTick <= 1'b0;
    wdOscTick <= 1'b0;
    mainTick <= 1'b0;
  endtask

  task automatic testResetValues();
    logic [31:0] d;
    rdExp(ADDR_MODE, 32'h0);
    rdExp(ADDR_TIMEOUT, 32'h0000ff);
    rdExp(ADDR_WINDOW, 32'hffffff);
    rdExp(ADDR_WARN, 32'h0);
    rdExp(ADDR_CLKSEL, 32'h0);
    rd(8'h1c, d);
    check(d, 32'h0, "unmapped data");
    check({30'h0, lastResp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h1c, 32'h1);
    check({30'h0, lastResp}, {30'h0, RESP_SLVERR}, "unmapped write");
  endtask

  task automatic testTimeoutRange();
    wr(ADDR_TIMEOUT, 32'h10);
    rdExp(ADDR_TIMEOUT, 32'hff);
    wr(ADDR_TIMEOUT, 32'hffffff);
    rdExp(ADDR_TIMEOUT, 32'hffffff);
    wr(ADDR_TIMEOUT, 32'h100);
    rdExp(ADDR_TIMEOUT, 32'h100);
    wr(ADDR_TIMEOUT, 32'hff);
  endtask

  // enable sticks, then an access between feed writes disables it by a fault
  task automatic testStickyAndBadFeed();
    logic [31:0] d;
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_MODE, 32'h0);
    rdExp(ADDR_MODE, 32'h1);
    wr(ADDR_FEED, {24'h0, FEED_FIRST});
    rd(ADDR_MODE, d);
    rdExp(ADDR_MODE, 32'h4);
    check({31'h0, wdIrq}, 32'h1, "irq on fault");
    wr(ADDR_MODE, 32'h4);
    rdExp(ADDR_MODE, 32'h0);
    check({31'h0, wdIrq}, 32'h0, "irq cleared");
  endtask

  task automatic testFeedAndWindow();
    wr(ADDR_MODE, 32'h1);
    feed();
    ticks(8, CLK_RCOSC);
    rdExp(ADDR_COUNT, 32'hfd);
    feed();
    rdExp(ADDR_COUNT, 32'hff);
    rdExp(ADDR_MODE, 32'h1);
    wr(ADDR_WINDOW, 32'h10);
    feed();
    rdExp(ADDR_MODE, 32'h4);
    wr(ADDR_MODE, 32'h4);
    wr(ADDR_WINDOW, 32'hffffff);
  endtask

  task automatic testClockAndWarning();
    wr(ADDR_CLKSEL, 32'h2);
    rdExp(ADDR_CLKSEL, 32'h0);
    wr(ADDR_CLKSEL, 32'h3);
    rdExp(ADDR_CLKSEL, 32'h0);
    wr(ADDR_CLKSEL, 32'h1);
    rdExp(ADDR_CLKSEL, 32'h1);
    wr(ADDR_WARN, 32'hfe);
    wr(ADDR_MODE, 32'h1);
    feed();
    ticks(4, CLK_RCOSC);
    rdExp(ADDR_COUNT, 32'hff);
    ticks(4, CLK_MAIN);
    rdExp(ADDR_COUNT, 32'hff);
    ticks(4, CLK_WDOSC);
    rdExp(ADDR_COUNT, 32'hfe);
    rdExp(ADDR_MODE, 32'h1);
    ticks(4, CLK_WDOSC);
    rdExp(ADDR_MODE, 32'h9);
    check({31'h0, wdIrq}, 32'h1, "warning irq");
    // wrong access after the first feed value disables the count
    wr(ADDR_FEED, {24'h0, FEED_FIRST});
    wr(ADDR_MODE, 32'hc);
    rdExp(ADDR_MODE, 32'h4);
    wr(ADDR_MODE, 32'h4);
    wr(ADDR_CLKSEL, 32'h0);
    wr(ADDR_WARN, 32'h0);
  endtask

  task automatic testExpiry();
    wr(ADDR_MODE, 32'h3);
    feed();
    ticks(1023, CLK_RCOSC);
    check(resetPulses, 0, "early reset");
    ticks(1, CLK_RCOSC);
    repeat (3) @(posedge clk_sys);
    check(resetPulses, 1, "expiry reset");
    // warning value 0 matches the expiring step, so the warning flag rises too
    rdExp(ADDR_MODE, 32'h1a);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdExp(ADDR_MODE, 32'h10);
    wr(ADDR_MODE, 32'h10);
    rdExp(ADDR_MODE, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    porRst_n <= 1'b1;
    @(posedge clk_sys);
    testResetValues();
    testTimeoutRange();
    testStickyAndBadFeed();
    testFeedAndWindow();
    testClockAndWarning();
    testExpiry();
    give_verdict();
  end
endmodule // windowed_watchdog_timer_tb_top
